// ===== rtl/sbf_pkg.sv
// Package for the shift, bit and flag execution unit: offsets, fields, opcodes and types
// ----------------------------------------------------------------
// What this block does
// - I/O bit clear zeroes one bit of an I/O register, no flags, two cycles.
// - Logical left shift moves bits up, zero into bit 0, sets Z C N V.
// - Logical right shift moves bits down, zero into bit 7, sets Z C N V.
// - Rotate left: old carry into bit 0, bit 7 into carry, Z C N V.
// - Rotate right: old carry into bit 7, bit 0 into carry, Z C N V.
// - Arithmetic right shift: bits 0 to 6 take the bit above, Z C N V.
// - Nibble swap exchanges the two halves, no flag changes, one cycle.
// - Generic flag set writes one into the selected status bit only.
// - Generic flag clear writes zero into the selected status bit only.
// - Bit store copies the selected register bit into T, only T changes.
// - Bit load copies T into the selected register bit, flags unchanged.
// - Dedicated ops set or clear C N Z S V T H one at a time.
// - Global interrupt on and off set or clear status bit I in one cycle.
// - Sleep takes one cycle, no flags, and pulses a sleep request.
// - Watchdog restart takes one cycle, no flags, pulses a restart.
// - Break changes no flags and hands control to the debug logic.
// ----------------------------------------------------------------
package sbf_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam int         ADDR_W       = 8;
    localparam logic [7:0] OFS_CMD      = 8'h00;
    localparam logic [7:0] OFS_OPERAND  = 8'h04;
    localparam logic [7:0] OFS_STATUS   = 8'h08;
    localparam logic [7:0] OFS_STATE    = 8'h0c;
    localparam logic [7:0] OFS_IO_BASE  = 8'h10;
    localparam int         IO_COUNT     = 4;
    localparam logic [7:0] OFS_IO_LAST  = 8'h1c;

    // ------------------------------------------------------------
    // Command word fields
    // ------------------------------------------------------------
    localparam int CMD_OP_LSB  = 0;
    localparam int OP_W        = 6;
    localparam int CMD_SEL_LSB = 8;
    localparam int SEL_W       = 3;
    localparam int CMD_IO_LSB  = 12;
    localparam int IO_IDX_W    = 2;

    // State register bits
    localparam int ST_BUSY  = 0;
    localparam int ST_DEBUG = 1;
    localparam int ST_BADOP = 2;

    // ------------------------------------------------------------
    // Status register bit positions
    // ------------------------------------------------------------
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_N = 2;
    localparam int FLAG_V = 3;
    localparam int FLAG_S = 4;
    localparam int FLAG_H = 5;
    localparam int FLAG_T = 6;
    localparam int FLAG_I = 7;

    // ------------------------------------------------------------
    // Opcodes
    // ------------------------------------------------------------
    localparam logic [5:0] OP_NO_OPERATION = 6'h00;
    localparam logic [5:0] OP_SLEEP        = 6'h01;
    localparam logic [5:0] OP_WATCHDOG     = 6'h02;
    localparam logic [5:0] OP_BREAK        = 6'h03;
    localparam logic [5:0] OP_IO_BIT_CLEAR = 6'h04;
    localparam logic [5:0] OP_SHIFT_FIRST  = 6'h08;
    localparam logic [5:0] OP_SHIFT_LAST   = 6'h0d;
    localparam logic [5:0] OP_FLAG_SET_GEN = 6'h10;
    localparam logic [5:0] OP_FLAG_CLR_GEN = 6'h11;
    localparam logic [5:0] OP_BIT_TO_T     = 6'h12;
    localparam logic [5:0] OP_T_TO_BIT     = 6'h13;
    localparam logic [5:0] OP_FLAG_SET_BASE = 6'h20;
    localparam logic [5:0] OP_FLAG_CLR_BASE = 6'h28;
    localparam logic [5:0] OP_GLOBAL_IRQ_ON  = 6'h27;
    localparam logic [5:0] OP_GLOBAL_IRQ_OFF = 6'h2f;

    // Shift unit kinds: low three opcode bits of 6'h08..6'h0d
    localparam logic [2:0] SH_LEFT_LOGICAL  = 3'h0;
    localparam logic [2:0] SH_RIGHT_LOGICAL = 3'h1;
    localparam logic [2:0] SH_ROTATE_LEFT   = 3'h2;
    localparam logic [2:0] SH_ROTATE_RIGHT  = 3'h3;
    localparam logic [2:0] SH_RIGHT_ARITH   = 3'h4;
    localparam logic [2:0] SH_NIBBLE_SWAP   = 3'h5;

    // Reset values
    localparam logic [7:0] RST_OPERAND = 8'h00;
    localparam logic [7:0] RST_STATUS  = 8'h00;
    localparam logic [7:0] RST_IO      = 8'h00;

    typedef enum logic [1:0] {
        SBF_IDLE,
        SBF_IOCLR,
        SBF_DEBUG
    } sbf_state_t;

endpackage : sbf_pkg

// ===== rtl/sbf_shift_unit.sv
// Combinational shifter for the shift, rotate and nibble swap operations
`timescale 1ns/1ns
`default_nettype none
module sbf_shift_unit (
    input  wire logic [2:0] kind,    // Shift kind
    input  wire logic [7:0] din,     // Register value
    input  wire logic       cin,     // Old carry
    output logic      [7:0] dout,    // Shifted value
    output logic            cout,    // New carry
    output logic            zOut,    // Result is zero
    output logic            nOut,    // Result bit 7
    output logic            vOut     // N xor C
);
    always_comb begin
        dout = din;
        cout = cin;
        unique case (kind)
            sbf_pkg::SH_LEFT_LOGICAL: begin
                dout = {din[6:0], 1'b0};
                cout = din[7];
            end
            sbf_pkg::SH_RIGHT_LOGICAL: begin
                dout = {1'b0, din[7:1]};
                cout = din[0];
            end
            sbf_pkg::SH_ROTATE_LEFT: begin
                dout = {din[6:0], cin};
                cout = din[7];
            end
            sbf_pkg::SH_ROTATE_RIGHT: begin
                dout = {cin, din[7:1]};
                cout = din[0];
            end
            sbf_pkg::SH_RIGHT_ARITH: begin
                dout = {din[7], din[7:1]};
                cout = din[0];
            end
            sbf_pkg::SH_NIBBLE_SWAP: begin
                dout = {din[3:0], din[7:4]};
            end
            default: begin
                dout = din;
            end
        endcase
        zOut = (dout == 8'h00);
        nOut = dout[7];
        vOut = dout[7] ^ cout;
    end
endmodule : sbf_shift_unit
`default_nettype wire

// ===== rtl/sbf_bit_unit.sv
// Single-bit replace and pick on a byte
`timescale 1ns/1ns
`default_nettype none
module sbf_bit_unit #(
    parameter int WIDTH = 8
) (
    input  wire logic [WIDTH-1:0]         din,     // Source value
    input  wire logic [$clog2(WIDTH)-1:0] sel,     // Bit index
    input  wire logic                     bitVal,  // Value to place
    output logic      [WIDTH-1:0]         dout,    // Source with bit replaced
    output logic                          bitOut   // Selected source bit
);
    always_comb begin
        dout      = din;
        dout[sel] = bitVal;
        bitOut    = din[sel];
    end
endmodule : sbf_bit_unit
`default_nettype wire

// ===== rtl/sbf_exec_unit.sv
// Shift, bit-transfer and flag execution unit with APB register access
`timescale 1ns/1ns
`default_nettype none
module sbf_exec_unit (
    input  wire logic        clk,          // Core clock, 50 MHz
    input  wire logic        rstn,         // Asynchronous reset, active low
    input  wire logic        psel,         // APB select
    input  wire logic        penable,      // APB enable
    input  wire logic        pwrite,       // APB write
    input  wire logic [7:0]  paddr,        // APB byte address
    input  wire logic [31:0] pwdata,       // APB write data
    output logic      [31:0] prdata,       // APB read data
    output logic             pready,       // APB ready
    output logic             pslverr,      // APB error, unmapped address
    input  wire logic        debugResume,  // Debug logic returns control
    output logic             sleepReq,     // Sleep request pulse
    output logic             wdtRestart,   // Watchdog restart pulse
    output logic             debugHalt,    // Core handed to debug logic
    output logic             globalIrqEn   // Interrupt enable bit of status
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        sbf_pkg::sbf_state_t                             state;
        logic [7:0]                                      operand;
        logic [7:0]                                      status;
        logic [sbf_pkg::IO_COUNT-1:0][7:0]               io;
        logic [sbf_pkg::IO_IDX_W-1:0]                    ioIdx;
        logic [sbf_pkg::SEL_W-1:0]                       ioBit;
        logic                                            sleepReq;
        logic                                            wdtRestart;
        logic                                            badOp;
    } sbf_regs_t;

    sbf_regs_t s_q;
    sbf_regs_t s_d;

    logic                          busy;
    logic                          access;
    logic                          wrTake;
    logic                          cmdTake;
    logic                          ioHit;
    logic                          mapped;
    logic [sbf_pkg::IO_IDX_W-1:0]  ioAddrIdx;
    logic [5:0]                    op;
    logic [2:0]                    cmdSel;
    logic [7:0]                    shOut;
    logic                          shC;
    logic                          shZ;
    logic                          shN;
    logic                          shV;
    logic [7:0]                    ioCleared;
    logic [2:0]                    flagSel;
    logic                          flagVal;
    logic [7:0]                    statusNew;
    logic [7:0]                    operandNew;
    logic                          operandBit;
    logic                          isShift;
    logic                          isDedicated;

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    // Every access stalls while an instruction is still executing, which
    // keeps software writes from racing the datapath.
    assign busy      = (s_q.state != sbf_pkg::SBF_IDLE);
    assign pready    = !busy;
    assign access    = psel && penable && pready;
    assign wrTake    = access && pwrite;
    assign cmdTake   = wrTake && (paddr == sbf_pkg::OFS_CMD);
    assign ioHit     = (paddr >= sbf_pkg::OFS_IO_BASE) && (paddr <= sbf_pkg::OFS_IO_LAST)
                       && (paddr[1:0] == 2'h0);
    assign ioAddrIdx = paddr[2 +: sbf_pkg::IO_IDX_W];
    assign mapped    = ioHit || (paddr == sbf_pkg::OFS_CMD) || (paddr == sbf_pkg::OFS_OPERAND)
                       || (paddr == sbf_pkg::OFS_STATUS) || (paddr == sbf_pkg::OFS_STATE);
    assign pslverr   = access && !mapped;

    always_comb begin
        prdata = 32'h0000_0000;
        if (paddr == sbf_pkg::OFS_OPERAND) begin
            prdata[7:0] = s_q.operand;
        end else if (paddr == sbf_pkg::OFS_STATUS) begin
            prdata[7:0] = s_q.status;
        end else if (paddr == sbf_pkg::OFS_STATE) begin
            prdata[sbf_pkg::ST_BUSY]  = busy;
            prdata[sbf_pkg::ST_DEBUG] = (s_q.state == sbf_pkg::SBF_DEBUG);
            prdata[sbf_pkg::ST_BADOP] = s_q.badOp;
        end else if (ioHit) begin
            prdata[7:0] = s_q.io[ioAddrIdx];
        end
    end

    // ------------------------------------------------------------
    // Datapath
    // ------------------------------------------------------------
    assign op          = pwdata[sbf_pkg::CMD_OP_LSB +: sbf_pkg::OP_W];
    assign cmdSel      = pwdata[sbf_pkg::CMD_SEL_LSB +: sbf_pkg::SEL_W];
    assign isShift     = (op >= sbf_pkg::OP_SHIFT_FIRST) && (op <= sbf_pkg::OP_SHIFT_LAST);
    assign isDedicated = (op[5:4] == 2'h2);
    // Dedicated ops carry the flag index in the low bits, bit 3 picks clear
    assign flagSel     = isDedicated ? op[2:0] : cmdSel;
    assign flagVal     = isDedicated ? !op[3] : (op == sbf_pkg::OP_FLAG_SET_GEN);

    sbf_shift_unit u_shift (
        .kind (op[2:0]),
        .din  (s_q.operand),
        .cin  (s_q.status[sbf_pkg::FLAG_C]),
        .dout (shOut),
        .cout (shC),
        .zOut (shZ),
        .nOut (shN),
        .vOut (shV)
    );

    sbf_bit_unit #(.WIDTH(8)) u_io_bit (
        .din    (s_q.io[s_q.ioIdx]),
        .sel    (s_q.ioBit),
        .bitVal (1'b0),
        .dout   (ioCleared),
        .bitOut ()
    );

    sbf_bit_unit #(.WIDTH(8)) u_flag_bit (
        .din    (s_q.status),
        .sel    (flagSel),
        .bitVal (flagVal),
        .dout   (statusNew),
        .bitOut ()
    );

    sbf_bit_unit #(.WIDTH(8)) u_reg_bit (
        .din    (s_q.operand),
        .sel    (cmdSel),
        .bitVal (s_q.status[sbf_pkg::FLAG_T]),
        .dout   (operandNew),
        .bitOut (operandBit)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_d            = s_q;
        s_d.sleepReq   = 1'b0;
        s_d.wdtRestart = 1'b0;
        unique case (s_q.state)
            sbf_pkg::SBF_IDLE: begin
                if (wrTake && (paddr == sbf_pkg::OFS_OPERAND)) begin
                    s_d.operand = pwdata[7:0];
                end
                if (wrTake && (paddr == sbf_pkg::OFS_STATUS)) begin
                    s_d.status = pwdata[7:0];
                end
                if (wrTake && ioHit) begin
                    s_d.io[ioAddrIdx] = pwdata[7:0];
                end
                // Writing the state word clears the bad opcode mark
                if (wrTake && (paddr == sbf_pkg::OFS_STATE)) begin
                    s_d.badOp = 1'b0;
                end
                if (cmdTake) begin
                    if (isShift) begin
                        s_d.operand = shOut;
                        if (op[2:0] != sbf_pkg::SH_NIBBLE_SWAP) begin
                            s_d.status[sbf_pkg::FLAG_C] = shC;
                            s_d.status[sbf_pkg::FLAG_Z] = shZ;
                            s_d.status[sbf_pkg::FLAG_N] = shN;
                            s_d.status[sbf_pkg::FLAG_V] = shV;
                        end
                    end else if (isDedicated || (op == sbf_pkg::OP_FLAG_SET_GEN)
                                 || (op == sbf_pkg::OP_FLAG_CLR_GEN)) begin
                        s_d.status = statusNew;
                    end else if (op == sbf_pkg::OP_BIT_TO_T) begin
                        s_d.status[sbf_pkg::FLAG_T] = operandBit;
                    end else if (op == sbf_pkg::OP_T_TO_BIT) begin
                        s_d.operand = operandNew;
                    end else if (op == sbf_pkg::OP_IO_BIT_CLEAR) begin
                        s_d.ioIdx = pwdata[sbf_pkg::CMD_IO_LSB +: sbf_pkg::IO_IDX_W];
                        s_d.ioBit = cmdSel;
                        s_d.state = sbf_pkg::SBF_IOCLR;
                    end else if (op == sbf_pkg::OP_SLEEP) begin
                        s_d.sleepReq = 1'b1;
                    end else if (op == sbf_pkg::OP_WATCHDOG) begin
                        s_d.wdtRestart = 1'b1;
                    end else if (op == sbf_pkg::OP_BREAK) begin
                        s_d.state = sbf_pkg::SBF_DEBUG;
                    end else if (op != sbf_pkg::OP_NO_OPERATION) begin
                        s_d.badOp = 1'b1;
                    end
                end
            end
            sbf_pkg::SBF_IOCLR: begin
                // Second cycle writes the cleared byte back
                s_d.io[s_q.ioIdx] = ioCleared;
                s_d.state         = sbf_pkg::SBF_IDLE;
            end
            sbf_pkg::SBF_DEBUG: begin
                if (debugResume) begin
                    s_d.state = sbf_pkg::SBF_IDLE;
                end
            end
            default: begin
                s_d.state = sbf_pkg::SBF_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q.state      <= sbf_pkg::SBF_IDLE;
            s_q.operand    <= sbf_pkg::RST_OPERAND;
            s_q.status     <= sbf_pkg::RST_STATUS;
            s_q.io         <= {sbf_pkg::IO_COUNT{sbf_pkg::RST_IO}};
            s_q.ioIdx      <= '0;
            s_q.ioBit      <= '0;
            s_q.sleepReq   <= 1'b0;
            s_q.wdtRestart <= 1'b0;
            s_q.badOp      <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign sleepReq    = s_q.sleepReq;
    assign wdtRestart  = s_q.wdtRestart;
    assign debugHalt   = (s_q.state == sbf_pkg::SBF_DEBUG);
    assign globalIrqEn = s_q.status[sbf_pkg::FLAG_I];

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_clr_wait;
        busy && (s_q.state == sbf_pkg::SBF_IOCLR);
    endsequence
    sequence s_clr_done;
        !busy && !s_q.io[$past(s_q.ioIdx)][$past(s_q.ioBit)];
    endsequence

    property p_io_clear;
        @(posedge clk) disable iff (!rstn)
        (cmdTake && op == sbf_pkg::OP_IO_BIT_CLEAR) |=> s_clr_wait ##1 s_clr_done;
    endproperty
    a_io_clear: assert property (p_io_clear) else $error("io bit clear wrong");

    property p_shl;
        @(posedge clk) disable iff (!rstn)
        (cmdTake && op == 6'h08) |=> (s_q.operand == {$past(s_q.operand[6:0]), 1'b0})
            && (s_q.status[sbf_pkg::FLAG_C] == $past(s_q.operand[7]));
    endproperty
    a_shl: assert property (p_shl) else $error("left shift wrong");

    property p_shr;
        @(posedge clk) disable iff (!rstn)
        (cmdTake && op == 6'h09) |=> (s_q.operand == {1'b0, $past(s_q.operand[7:1])})
            && (s_q.status[sbf_pkg::FLAG_Z] == (s_q.operand == 8'h00));
    endproperty
    a_shr: assert property (p_shr) else $error("right shift wrong");

    property p_rot_left;
        @(posedge clk) disable iff (!rstn)
        (cmdTake && op == 6'h0a) |=> (s_q.operand[0] == $past(s_q.status[sbf_pkg::FLAG_C]))
            && (s_q.status[sbf_pkg::FLAG_C] == $past(s_q.operand[7]));
    endproperty
    a_rot_left: assert property (p_rot_left) else $error("rotate left wrong");

    property p_rot_right;
        @(posedge clk) disable iff (!rstn)
        (cmdTake && op == 6'h0b) |=> (s_q.operand[7] == $past(s_q.status[sbf_pkg::FLAG_C]))
            && (s_q.status[sbf_pkg::FLAG_V] == (s_q.operand[7] ^ s_q.status[sbf_pkg::FLAG_C]));
    endproperty
    a_rot_right: assert property (p_rot_right) else $error("rotate right wrong");

    property p_shr_arith;
        @(posedge clk) disable iff (!rstn)
        (cmdTake && op == 6'h0c) |=> (s_q.operand == {$past(s_q.operand[7]),
            $past(s_q.operand[7:1])}) && (s_q.status[sbf_pkg::FLAG_C] == $past(s_q.operand[0]));
    endproperty
    a_shr_arith: assert property (p_shr_arith) else $error("arith shift wrong");

    property p_swap;
        @(posedge clk) disable iff (!rstn)
        (cmdTake && op == 6'h0d) |=> $stable(s_q.status)
            && (s_q.operand == {$past(s_q.operand[3:0]), $past(s_q.operand[7:4])});
    endproperty
    a_swap: assert property (p_swap) else $error("nibble swap wrong");

    property p_bit_store;
        @(posedge clk) disable iff (!rstn)
        (cmdTake && op == sbf_pkg::OP_BIT_TO_T) |=>
            (s_q.status[sbf_pkg::FLAG_T] == $past(s_q.operand[cmdSel]))
            && (s_q.status[5:0] == $past(s_q.status[5:0]))
            && (s_q.status[7] == $past(s_q.status[7])) && $stable(s_q.operand);
    endproperty
    a_bit_store: assert property (p_bit_store) else $error("bit store wrong");

    property p_sleep;
        @(posedge clk) disable iff (!rstn)
        (cmdTake && op == sbf_pkg::OP_SLEEP) |=> sleepReq && $stable(s_q.status) ##1 !sleepReq;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep pulse wrong");

    property p_irq_on;
        @(posedge clk) disable iff (!rstn)
        (cmdTake && op == sbf_pkg::OP_GLOBAL_IRQ_ON) |=> globalIrqEn
            && (s_q.status[6:0] == $past(s_q.status[6:0]));
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("irq enable wrong");

endmodule : sbf_exec_unit
`default_nettype wire

// ===== test/sbf_debug_model.sv
// Debug logic model that hands control back some cycles after a halt
`timescale 1ns/1ns
`default_nettype none
module sbf_debug_model #(
    parameter int DELAY = 3  // Halted cycles before resume is raised
) (
    input  wire logic clk,         // Core clock
    input  wire logic rstn,        // Reset, active low
    input  wire logic debugHalt,   // Core handed over
    output logic      debugResume  // Control given back
);
    int cnt;
    // Resume is registered from halt, so it stays high one cycle after the core is idle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt <= 0;
            debugResume <= 1'b0;
        end else begin
            cnt <= debugHalt ? cnt + 1 : 0;
            debugResume <= debugHalt && (cnt >= DELAY - 1);
        end
    end
endmodule : sbf_debug_model
`default_nettype wire

// ===== test/tb_top.sv
// Testbench for the shift, bit and flag execution unit
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic        clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic        pready, pslverr, debugResume, sleepReq, wdtRestart, debugHalt, globalIrqEn, err;
    int          fails = 0, cmp_count = 0, waits;
    logic [7:0]  shRes [6] = '{8'h02, 8'h40, 8'h03, 8'hc0, 8'hc0, 8'h18};
    logic [7:0]  shSt [6] = '{8'h39, 8'h39, 8'h39, 8'h35, 8'h35, 8'h31};

    always #10 clk = ~clk;

    sbf_exec_unit dut_u (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .debugResume(debugResume), .sleepReq(sleepReq),
        .wdtRestart(wdtRestart), .debugHalt(debugHalt), .globalIrqEn(globalIrqEn));
    sbf_debug_model dbg_u (.clk(clk), .rstn(rstn), .debugHalt(debugHalt),
        .debugResume(debugResume));

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        waits = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            waits++;
        end while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
        apb(1'b0, a, 32'h0);
        chk(n, e, rdat);
    endtask : rd
    task automatic op(input logic [5:0] o, input int s = 0, input int io = 0);
        apb(1'b1, 8'h00, {18'h0, 2'(io), 1'b0, 3'(s), 2'b00, o});
    endtask : op
    task automatic close_out;
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out

    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #100000;
        fails++;
        close_out();
    end

    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rd(8'h08, 32'h0, "status reset");
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, 8'h04, 32'h81);
            apb(1'b1, 8'h08, 32'h31);
            op(sbf_pkg::OP_SHIFT_FIRST + 6'(i));
            rd(8'h04, 32'(shRes[i]), "shift result");
            rd(8'h08, 32'(shSt[i]), "shift flags");
        end
        apb(1'b1, 8'h04, 32'h80);
        apb(1'b1, 8'h08, 32'h0);
        op(sbf_pkg::OP_SHIFT_FIRST);
        rd(8'h08, 32'h0b, "shift zero flags");
        $display("shift test done");
        for (int i = 0; i < 16; i++) begin
            apb(1'b1, 8'h08, 32'h0);
            if (i < 8) op(sbf_pkg::OP_FLAG_SET_BASE + 6'(i));
            else op(sbf_pkg::OP_FLAG_SET_GEN, i - 8);
            rd(8'h08, 32'h1 << (i % 8), "flag set");
            chk("irq enable", 32'(i % 8 == 7), {31'h0, globalIrqEn});
            apb(1'b1, 8'h08, 32'hff);
            if (i < 8) op(sbf_pkg::OP_FLAG_CLR_BASE + 6'(i));
            else op(sbf_pkg::OP_FLAG_CLR_GEN, i - 8);
            rd(8'h08, 32'hff & ~(32'h1 << (i % 8)), "flag clear");
        end
        $display("flag test done");
        apb(1'b1, 8'h04, 32'h04);
        apb(1'b1, 8'h08, 32'h0);
        op(sbf_pkg::OP_BIT_TO_T, 2);
        rd(8'h08, 32'h40, "bit to T");
        op(sbf_pkg::OP_T_TO_BIT, 5);
        rd(8'h04, 32'h24, "T to bit");
        rd(8'h08, 32'h40, "T to bit flags");
        op(sbf_pkg::OP_BIT_TO_T, 0);
        rd(8'h08, 32'h0, "zero bit to T");
        op(sbf_pkg::OP_NO_OPERATION);
        rd(8'h04, 32'h24, "nop operand");
        $display("bit test done");
        apb(1'b1, 8'h14, 32'hff);
        apb(1'b1, 8'h18, 32'hff);
        op(sbf_pkg::OP_IO_BIT_CLEAR, 3, 1);
        #1 chk("io clear busy", 32'h0, {31'h0, pready});
        @(posedge clk);
        #1 chk("io clear idle", 32'h1, {31'h0, pready});
        rd(8'h14, 32'hf7, "io cleared");
        rd(8'h18, 32'hff, "io other");
        rd(8'h08, 32'h0, "io flags");
        op(sbf_pkg::OP_SLEEP);
        #1 chk("sleep pulse", 32'h1, {31'h0, sleepReq});
        op(sbf_pkg::OP_WATCHDOG);
        #1 chk("restart pulse", 32'h1, {31'h0, wdtRestart});
        chk("sleep pulse end", 32'h0, {31'h0, sleepReq});
        op(sbf_pkg::OP_BREAK);
        #1 chk("debug halt", 32'h1, {31'h0, debugHalt});
        chk("restart pulse end", 32'h0, {31'h0, wdtRestart});
        rd(8'h0c, 32'h0, "state after resume");
        chk("debug wait", 32'h1, {31'h0, waits > 2});
        rd(8'h08, 32'h0, "control flags");
        $display("control test done");
        op(6'h3f);
        rd(8'h0c, 32'h4, "bad opcode");
        apb(1'b1, 8'h20, 32'hff);
        chk("unmapped error", 32'h1, {31'h0, err});
        rd(8'h20, 32'h0, "unmapped read");
        rd(8'h00, 32'h0, "command read");
        $display("map test done");
        close_out();
    end
endmodule : tb_top
`default_nettype wire
